// ---- rtl/dspk_exec.sv ----
/*
 execution unit for the stack, product transfer and port output operations.
 assumes a sequencer presents one operation with I_OP_VALID while O_BUSY is
 low, supplies the memory operand on I_MEM_DATA at issue and for each repeated
 word on I_SRC_DATA with I_SRC_VALID, and honours the external ready line.
*/
// Overview of operation
// - repeated port output sends repeat counter at start plus one words.
// - port address steps up by one after every repeated word written.
// - after the pipeline fills, each further repeated word takes one cycle.
// - single port output takes one more cycle with shared single access ram.
// - product transfer loads accumulator with product shifted by shift mode.
// - pop to accumulator fills low half, clears high half, pops stack.
// - last-in first-out hardware stack with exactly eight locations.
// - pop moves each entry up one; bottom keeps value.
// - no underflow check; many pops leave all levels equal.
// - pop to memory writes top to data word and pops stack.
// - push from memory shifts stack down then puts data word on top.
// - push from accumulator shifts stack down, puts accumulator low on top.
// - pop or push with memory adds one cycle when ram block shared.
// - port output drives io select low with external write handshake.
// - port addresses 50h to 5Fh go to mapped locations, others external.
`timescale 1ns/1ps
module dspk_exec #(
   parameter int unsigned DW = dspk_pkg::DATA_W
) (
   // clock, reset, enable
   input  wire logic                 I_CLK,
   input  wire logic                 I_SYS_RST,
   input  wire logic                 I_CE,
   // operation issue
   input  wire logic                 I_OP_VALID,
   input  wire dspk_pkg::dspk_op_t   I_OP,
   input  wire logic                 I_SHARED_RAM,
   input  wire logic                 I_REPEAT,
   input  wire logic [15:0]          I_REPEAT_COUNTER,
   input  wire logic [15:0]          I_PORT_ADDR,
   input  wire logic [DW-1:0]        I_MEM_DATA,
   input  wire logic [31:0]          I_PRODUCT_REGISTER,
   input  wire logic [1:0]           I_PRODUCT_SHIFT_MODE,
   // repeated source words
   input  wire logic                 I_SRC_VALID,
   input  wire logic [DW-1:0]        I_SRC_DATA,
   // external io handshake
   input  wire logic                 I_READY,
   // status and results
   output logic                      O_BUSY,
   output logic                      O_DONE,
   output logic [31:0]               O_ACCUMULATOR,
   output logic [DW-1:0]             O_STACK_TOP_ENTRY,
   output logic                      O_SRC_TAKE,
   // data memory write for pop to memory
   output logic                      O_MEM_WE,
   output logic [DW-1:0]             O_MEM_WDATA,
   // io port bus
   output logic                      O_IO_SPACE_SELECT_N,
   output logic                      O_STRB_N,
   output logic                      O_RW,
   output logic [15:0]               O_IO_ADDR,
   output logic [DW-1:0]             O_IO_DATA,
   output logic                      O_MMAP_WE,
   output logic [3:0]                O_MMAP_SEL,
   output logic [DW-1:0]             O_MMAP_DATA
);
   dspk_pkg::dspk_state_t state_r;
   dspk_pkg::dspk_op_t    op_r;
   logic [15:0]           left_r;
   logic [DW-1:0]         word_r;
   logic                  rep_r;
   logic                  st_push;
   logic                  st_pop;
   logic [DW-1:0]         st_data;
   logic                  issue;
   logic                  io_done;

   function automatic logic is_mmap(input logic [15:0] a);
      return (a >= dspk_pkg::MMAP_IO_LO) && (a <= dspk_pkg::MMAP_IO_HI);
   endfunction

   function automatic logic [31:0] shift_prod(input logic [31:0] p, input logic [1:0] m);
      if (m == dspk_pkg::SHIFT_LEFT1) begin
         return p << 1;
      end else if (m == dspk_pkg::SHIFT_LEFT4) begin
         return p << 4;
      end else if (m == dspk_pkg::SHIFT_RIGHT6) begin
         return 32'($signed(p) >>> 6);
      end
      return p;
   endfunction

   assign issue = I_CE && I_OP_VALID && (state_r == dspk_pkg::ST_IDLE);
   // external words finish on ready; mapped words finish at once
   assign io_done = (state_r == dspk_pkg::ST_XFER) && (!O_STRB_N)
                    && (O_MMAP_WE || I_READY);

   // stack moves happen at issue; pop wins in the stack if both asserted
   always_comb begin
      st_push = 1'b0;
      st_pop  = 1'b0;
      st_data = I_MEM_DATA;
      if (issue) begin
         case (I_OP)
            dspk_pkg::OP_POPA: st_pop = 1'b1;
            dspk_pkg::OP_POPM: st_pop = 1'b1;
            dspk_pkg::OP_PSHM: st_push = 1'b1;
            dspk_pkg::OP_PSHA: begin
               st_push = 1'b1;
               st_data = O_ACCUMULATOR[DW-1:0];
            end
            default: st_push = 1'b0;
         endcase
      end
   end

   dspk_stack #(
      .WIDTH (DW),
      .DEPTH (dspk_pkg::STACK_DEPTH)
   ) u_stack (
      .clk       (I_CLK),
      .rst       (I_SYS_RST),
      .en        (I_CE),
      .push      (st_push),
      .pop       (st_pop),
      .push_data (st_data),
      .top_r     (O_STACK_TOP_ENTRY)
   );

   // sequencing: shared ram costs one wait cycle before completion
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state_r <= dspk_pkg::ST_IDLE;
         op_r    <= dspk_pkg::OP_NONE;
         rep_r   <= 1'b0;
         left_r  <= 16'h0000;
         word_r  <= dspk_pkg::DATA_RST;
      end else if (I_CE) begin
         case (state_r)
            dspk_pkg::ST_IDLE: begin
               if (issue) begin
                  op_r   <= I_OP;
                  word_r <= I_MEM_DATA;
                  rep_r  <= I_REPEAT;
                  left_r <= I_REPEAT ? I_REPEAT_COUNTER : 16'h0000;
                  if (I_SHARED_RAM && !I_REPEAT) begin
                     state_r <= dspk_pkg::ST_WAIT;
                  end else if (I_OP == dspk_pkg::OP_OUT) begin
                     state_r <= dspk_pkg::ST_XFER;
                  end
               end
            end
            dspk_pkg::ST_WAIT: begin
               state_r <= (op_r == dspk_pkg::OP_OUT) ? dspk_pkg::ST_XFER
                                                     : dspk_pkg::ST_IDLE;
            end
            dspk_pkg::ST_XFER: begin
               if (io_done) begin
                  if (left_r == 16'h0000) begin
                     state_r <= dspk_pkg::ST_IDLE;
                  end else begin
                     left_r <= left_r - 16'h0001;
                     if (I_SRC_VALID) begin
                        word_r <= I_SRC_DATA;
                     end else begin
                        state_r <= dspk_pkg::ST_STALL;
                     end
                  end
               end
            end
            dspk_pkg::ST_STALL: begin
               if (I_SRC_VALID) begin
                  word_r  <= I_SRC_DATA;
                  state_r <= dspk_pkg::ST_XFER;
               end
            end
            default: state_r <= dspk_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_SRC_TAKE <= 1'b0;
      end else if (I_CE) begin
         O_SRC_TAKE <= I_SRC_VALID && ((io_done && left_r != 16'h0000)
                       || state_r == dspk_pkg::ST_STALL);
      end
   end

   // io bus outputs: address steps after each word
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_IO_SPACE_SELECT_N <= 1'b1;
         O_STRB_N            <= 1'b1;
         O_RW                <= 1'b1;
         O_IO_ADDR           <= 16'h0000;
         O_IO_DATA           <= dspk_pkg::DATA_RST;
         O_MMAP_WE           <= 1'b0;
         O_MMAP_SEL          <= 4'h0;
         O_MMAP_DATA         <= dspk_pkg::DATA_RST;
      end else if (I_CE) begin
         if (issue) begin
            O_IO_ADDR <= I_PORT_ADDR;
            O_IO_DATA <= I_MEM_DATA;
         end else if (io_done) begin
            O_IO_ADDR <= O_IO_ADDR + 16'h0001;
            O_IO_DATA <= I_SRC_DATA;
         end else if (state_r == dspk_pkg::ST_STALL) begin
            O_IO_DATA <= I_SRC_DATA;
         end
         if ((state_r == dspk_pkg::ST_XFER && !io_done)
             || (io_done && left_r != 16'h0000 && I_SRC_VALID)
             || (state_r == dspk_pkg::ST_STALL && I_SRC_VALID)
             || (state_r == dspk_pkg::ST_WAIT && op_r == dspk_pkg::OP_OUT)
             || (issue && I_OP == dspk_pkg::OP_OUT
                 && !(I_SHARED_RAM && !I_REPEAT))) begin
            // mapped ports never leave the chip
            if (is_mmap(io_done ? O_IO_ADDR + 16'h0001
                        : (issue ? I_PORT_ADDR : O_IO_ADDR))) begin
               O_IO_SPACE_SELECT_N <= 1'b1;
               O_MMAP_WE           <= 1'b1;
               O_MMAP_SEL          <= io_done ? 4'(O_IO_ADDR + 16'h0001)
                                     : (issue ? I_PORT_ADDR[3:0] : O_IO_ADDR[3:0]);
               O_MMAP_DATA         <= (io_done || state_r == dspk_pkg::ST_STALL)
                                      ? I_SRC_DATA : (issue ? I_MEM_DATA : word_r);
            end else begin
               O_IO_SPACE_SELECT_N <= 1'b0;
               O_MMAP_WE           <= 1'b0;
            end
            O_STRB_N <= 1'b0;
            O_RW     <= 1'b0;
         end else begin
            O_IO_SPACE_SELECT_N <= 1'b1;
            O_STRB_N            <= 1'b1;
            O_RW                <= 1'b1;
            O_MMAP_WE           <= 1'b0;
         end
      end
   end

   // accumulator and memory write results
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_ACCUMULATOR <= dspk_pkg::ACC_RST;
         O_MEM_WE      <= 1'b0;
         O_MEM_WDATA   <= dspk_pkg::DATA_RST;
      end else if (I_CE) begin
         O_MEM_WE <= 1'b0;
         if (issue && I_OP == dspk_pkg::OP_PROD) begin
            O_ACCUMULATOR <= shift_prod(I_PRODUCT_REGISTER, I_PRODUCT_SHIFT_MODE);
         end else if (issue && I_OP == dspk_pkg::OP_POPA) begin
            O_ACCUMULATOR <= {16'h0000, O_STACK_TOP_ENTRY};
         end else if (issue && I_OP == dspk_pkg::OP_POPM) begin
            O_MEM_WE    <= 1'b1;
            O_MEM_WDATA <= O_STACK_TOP_ENTRY;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_BUSY <= 1'b0;
         O_DONE <= 1'b0;
      end else if (I_CE) begin
         O_DONE <= (issue && I_OP != dspk_pkg::OP_OUT && !(I_SHARED_RAM && !I_REPEAT))
                   || (state_r == dspk_pkg::ST_WAIT && op_r != dspk_pkg::OP_OUT)
                   || (io_done && left_r == 16'h0000);
         O_BUSY <= (issue && (I_OP == dspk_pkg::OP_OUT || (I_SHARED_RAM && !I_REPEAT)))
                   || (state_r == dspk_pkg::ST_WAIT && op_r == dspk_pkg::OP_OUT)
                   || (state_r == dspk_pkg::ST_XFER && !(io_done && left_r == 16'h0000))
                   || state_r == dspk_pkg::ST_STALL;
      end
   end
endmodule

// ---- rtl/dspk_pkg.sv ----
/*
 package for the stack and port transfer execution block: operation codes,
 widths, reset values and map constants. assumes nothing of its surroundings.
*/
package dspk_pkg;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned ACC_W         = 32;
   localparam int unsigned STACK_DEPTH   = 8;
   localparam int unsigned RPT_W         = 16;
   localparam logic [15:0] MMAP_IO_LO    = 16'h0050;
   localparam logic [15:0] MMAP_IO_HI    = 16'h005F;
   localparam logic [15:0] DATA_RST      = 16'h0000;
   localparam logic [31:0] ACC_RST       = 32'h0000_0000;
   localparam logic [1:0]  SHIFT_NONE    = 2'h0;
   localparam logic [1:0]  SHIFT_LEFT1   = 2'h1;
   localparam logic [1:0]  SHIFT_LEFT4   = 2'h2;
   localparam logic [1:0]  SHIFT_RIGHT6  = 2'h3;
   localparam int unsigned SHARED_WAIT   = 1;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_PROD  = 3'h1,
      OP_POPA  = 3'h2,
      OP_POPM  = 3'h3,
      OP_PSHM  = 3'h4,
      OP_PSHA  = 3'h5,
      OP_OUT   = 3'h6
   } dspk_op_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_XFER  = 4'b0100,
      ST_STALL = 4'b1000
   } dspk_state_t;
endpackage

// ---- rtl/dspk_stack.sv ----
/*
 eight level last-in first-out word stack with a registered top output.
 assumes at most one push or pop per enabled cycle; pop wins if both.
*/
`timescale 1ns/1ps
module dspk_stack #(
   parameter int unsigned WIDTH = dspk_pkg::DATA_W,
   parameter int unsigned DEPTH = dspk_pkg::STACK_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             en,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top_r
);
   logic [WIDTH-1:0] lvl_r [DEPTH];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            lvl_r[i] <= WIDTH'(0);
         end
      end else if (en && pop) begin
         // bottom keeps its value, so repeated pops flood it upward
         for (int i = 0; i < DEPTH - 1; i++) begin
            lvl_r[i] <= lvl_r[i+1];
         end
      end else if (en && push) begin
         for (int i = 1; i < DEPTH; i++) begin
            lvl_r[i] <= lvl_r[i-1];
         end
         lvl_r[0] <= push_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         top_r <= WIDTH'(0);
      end else if (en && pop) begin
         top_r <= lvl_r[1];
      end else if (en && push) begin
         top_r <= push_data;
      end
   end
endmodule

// ---- tb/dspk_io_periph.sv ----
/*
 model of a peripheral in external io port space: answers ready and logs
 every word written. assumes the select, strobe and direction of the unit.
*/
`timescale 1ns/1ps
module dspk_io_periph (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        sel_n,
   input  wire logic        strb_n,
   input  wire logic        rw,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] data,
   output logic             ready
);
   logic [1:0]  w = 2'h0;
   logic [15:0] la[$];
   logic [15:0] ld[$];
   // slow mode holds two wait cycles per word; ready is low when not selected
   assign ready = !sel_n && !strb_n && (!slow || w == 2'h2);
   always @(posedge clk) begin
      w <= (strb_n || ready) ? 2'h0 : w + 2'h1;
      if (ready && !rw) begin
         la.push_back(addr);
         ld.push_back(data);
      end
   end
endmodule

// ---- tb/dspk_exec_chk.sv ----
/*
 assertions on the stack and port transfer unit.
 assumes it is bound to dspk_exec and sees only its ports.
*/
`timescale 1ns/1ps
module dspk_exec_chk (
   // clock, reset, enable
   input  wire logic               I_CLK,
   input  wire logic               I_SYS_RST,
   input  wire logic               I_CE,
   // operation issue and handshake inputs
   input  wire logic               I_OP_VALID,
   input  wire dspk_pkg::dspk_op_t I_OP,
   input  wire logic               I_SHARED_RAM,
   input  wire logic               I_REPEAT,
   input  wire logic               I_SRC_VALID,
   input  wire logic               I_READY,
   input  wire logic [15:0]        I_MEM_DATA,
   input  wire logic [31:0]        I_PRODUCT_REGISTER,
   input  wire logic [1:0]         I_PRODUCT_SHIFT_MODE,
   // watched results
   input  wire logic               O_BUSY,
   input  wire logic               O_DONE,
   input  wire logic               O_MEM_WE,
   input  wire logic               O_IO_SPACE_SELECT_N,
   input  wire logic               O_STRB_N,
   input  wire logic               O_RW,
   input  wire logic               O_MMAP_WE,
   input  wire logic [31:0]        O_ACCUMULATOR,
   input  wire logic [15:0]        O_STACK_TOP_ENTRY,
   input  wire logic [15:0]        O_MEM_WDATA,
   input  wire logic [15:0]        O_IO_ADDR
);
   logic        iss;
   logic [15:0] acc_lo;
   assign iss    = I_CE && I_OP_VALID && !O_BUSY;
   assign acc_lo = O_ACCUMULATOR[15:0];
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   property p_popa;
      iss && I_OP == dspk_pkg::OP_POPA && !I_SHARED_RAM |=>
         O_DONE && O_ACCUMULATOR == {16'h0000, $past(O_STACK_TOP_ENTRY)};
   endproperty
   a_popa: assert property (p_popa) else $error("pop to accumulator wrong");
   property p_pshm;
      iss && I_OP == dspk_pkg::OP_PSHM && !I_SHARED_RAM |=>
         O_STACK_TOP_ENTRY == $past(I_MEM_DATA);
   endproperty
   a_pshm: assert property (p_pshm) else $error("push from memory wrong");
   property p_psha;
      iss && I_OP == dspk_pkg::OP_PSHA |=> O_STACK_TOP_ENTRY == $past(acc_lo);
   endproperty
   a_psha: assert property (p_psha) else $error("push from acc wrong");
   property p_popm;
      iss && I_OP == dspk_pkg::OP_POPM && !I_SHARED_RAM |=>
         O_MEM_WE && O_MEM_WDATA == $past(O_STACK_TOP_ENTRY);
   endproperty
   a_popm: assert property (p_popm) else $error("pop to memory wrong");
   property p_slow;
      iss && (I_OP == dspk_pkg::OP_POPM || I_OP == dspk_pkg::OP_PSHM) &&
         I_SHARED_RAM && !I_REPEAT |=> !O_DONE ##1 O_DONE;
   endproperty
   a_slow: assert property (p_slow) else $error("shared ram wait wrong");
   property p_prod;
      iss && I_OP == dspk_pkg::OP_PROD && !I_SHARED_RAM &&
         I_PRODUCT_SHIFT_MODE == dspk_pkg::SHIFT_NONE |=>
         O_ACCUMULATOR == $past(I_PRODUCT_REGISTER);
   endproperty
   a_prod: assert property (p_prod) else $error("product transfer wrong");
   property p_out_sh;
      iss && I_OP == dspk_pkg::OP_OUT && I_SHARED_RAM && !I_REPEAT |=>
         O_STRB_N ##1 !O_STRB_N;
   endproperty
   a_out_sh: assert property (p_out_sh) else $error("shared out strobe wrong");
   property p_step;
      !O_IO_SPACE_SELECT_N && !O_STRB_N && I_READY && I_SRC_VALID && I_CE |=>
         O_STRB_N || O_IO_ADDR == $past(O_IO_ADDR) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("port address step wrong");
   property p_wr;
      !O_IO_SPACE_SELECT_N && !O_STRB_N |-> !O_RW;
   endproperty
   a_wr: assert property (p_wr) else $error("io access not a write");
   property p_map;
      O_MMAP_WE |-> O_IO_SPACE_SELECT_N;
   endproperty
   a_map: assert property (p_map) else $error("mapped port hit io space");
   c_popa: cover property (iss && I_OP == dspk_pkg::OP_POPA);
   c_rep: cover property (iss && I_OP == dspk_pkg::OP_OUT && I_REPEAT);
   c_map: cover property (O_MMAP_WE);
endmodule
bind dspk_exec dspk_exec_chk chk_u (.*);

// ---- tb/tb_dsp_stack_and_port_transfer_ops.sv ----
/*
 self-checking bench for the stack and port transfer unit.
 assumes the package, the peripheral model and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_dsp_stack_and_port_transfer_ops;
   logic               I_CLK = 0, I_SYS_RST = 1, I_CE = 1, I_OP_VALID = 0;
   logic               I_SHARED_RAM = 0, I_REPEAT = 0, I_SRC_VALID = 1, slow = 0, gap = 0;
   dspk_pkg::dspk_op_t I_OP = dspk_pkg::OP_NONE;
   logic [15:0]        I_REPEAT_COUNTER = 0, I_PORT_ADDR = 0;
   logic [15:0]        I_MEM_DATA = 0, I_SRC_DATA = 0, mm_d, stk[8];
   logic [31:0]        I_PRODUCT_REGISTER = 0, e;
   logic [1:0]         I_PRODUCT_SHIFT_MODE = 0;
   logic [3:0]         mm_s;
   wire                I_READY, busy, done, take, mwe, sel_n, strb_n, rw, mmwe;
   wire  [31:0]        acc;
   wire  [15:0]        top, mwd, ioa, iod, mmd;
   wire  [3:0]         mms;
   int                 n_mismatch = 0, n_checks = 0, i, mm_n = 0, n_take = 0;
   always #2 I_CLK = ~I_CLK;
   dspk_exec dut_u (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE),
      .I_OP_VALID(I_OP_VALID), .I_OP(I_OP), .I_SHARED_RAM(I_SHARED_RAM),
      .I_REPEAT(I_REPEAT), .I_REPEAT_COUNTER(I_REPEAT_COUNTER),
      .I_PORT_ADDR(I_PORT_ADDR), .I_MEM_DATA(I_MEM_DATA),
      .I_PRODUCT_REGISTER(I_PRODUCT_REGISTER), .I_PRODUCT_SHIFT_MODE(I_PRODUCT_SHIFT_MODE),
      .I_SRC_VALID(I_SRC_VALID), .I_SRC_DATA(I_SRC_DATA), .I_READY(I_READY),
      .O_BUSY(busy), .O_DONE(done), .O_ACCUMULATOR(acc), .O_STACK_TOP_ENTRY(top),
      .O_SRC_TAKE(take), .O_MEM_WE(mwe), .O_MEM_WDATA(mwd),
      .O_IO_SPACE_SELECT_N(sel_n), .O_STRB_N(strb_n), .O_RW(rw), .O_IO_ADDR(ioa),
      .O_IO_DATA(iod), .O_MMAP_WE(mmwe), .O_MMAP_SEL(mms), .O_MMAP_DATA(mmd));
   dspk_io_periph periph_u (.clk(I_CLK), .slow(slow), .sel_n(sel_n), .strb_n(strb_n),
      .rw(rw), .addr(ioa), .data(iod), .ready(I_READY));
   // next source word is offered right after the previous one is consumed
   // gap mode drops valid every other cycle so the unit has to stall
   always @(posedge I_CLK) begin
      I_SRC_VALID <= !gap || !I_SRC_VALID;
      if (gap ? take === 1'b1 : (!sel_n && !strb_n && I_READY))
         I_SRC_DATA <= I_SRC_DATA + 16'h0101;
      if (take === 1'b1)
         n_take++;
      if (mmwe === 1'b1) begin
         mm_n++;
         mm_s <= mms;
         mm_d <= mmd;
      end
   end
   task wrap_up;
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task op(input dspk_pkg::dspk_op_t o, input logic [15:0] d, input logic sh);
      @(posedge I_CLK);
      I_OP <= o;
      I_MEM_DATA <= d;
      I_SHARED_RAM <= sh;
      I_OP_VALID <= 1'b1;
      @(posedge I_CLK);
      I_OP_VALID <= 1'b0;
      #1;
   endtask
   task push_m(input logic [15:0] d);
      for (int k = 7; k > 0; k--) stk[k] = stk[k-1];
      stk[0] = d;
   endtask
   task t_stack;
      for (int k = 0; k < 8; k++) stk[k] = 16'h0000;
      for (i = 0; i < 9; i++) begin
         op(dspk_pkg::OP_PSHM, 16'hA000 + 16'(i), 1'b0);
         push_m(16'hA000 + 16'(i));
         `CHK(top, stk[0])
      end
      // ten pops: the bottom word spreads to every level
      for (i = 0; i < 10; i++) begin
         op(dspk_pkg::OP_POPA, 16'h0000, 1'b0);
         `CHK(acc, {16'h0000, stk[0]})
         for (int k = 0; k < 7; k++) stk[k] = stk[k+1];
         `CHK(top, stk[0])
      end
      `CHK(top, 16'hA001)
   endtask
   task t_prod;
      @(posedge I_CLK);
      I_PRODUCT_REGISTER <= 32'h8000_0123;
      for (i = 0; i < 4; i++) begin
         @(posedge I_CLK);
         I_PRODUCT_SHIFT_MODE <= 2'(i);
         op(dspk_pkg::OP_PROD, 16'h0000, 1'b0);
         e = i == 0 ? 32'h8000_0123 : i == 1 ? 32'h0000_0246 :
             i == 2 ? 32'h0000_1230 : 32'hFE00_0004;
         `CHK(acc, e)
      end
      op(dspk_pkg::OP_PSHA, 16'h0000, 1'b0);
      `CHK(top, 16'h0004)
      op(dspk_pkg::OP_POPM, 16'h0000, 1'b0);
      `CHK({mwe, mwd}, 17'h1_0004)
   endtask
   task t_shared;
      op(dspk_pkg::OP_PSHM, 16'h3C3C, 1'b1);
      `CHK(done, 1'b0)
      @(posedge I_CLK);
      #1;
      `CHK({done, top}, 17'h1_3C3C)
      op(dspk_pkg::OP_POPM, 16'h0000, 1'b1);
      `CHK({done, mwe, mwd, top}, 34'h1_3C3C_A001)
      @(posedge I_CLK);
      #1;
      `CHK(done, 1'b1)
   endtask
   task t_freeze;
      @(posedge I_CLK);
      I_CE <= 1'b0;
      op(dspk_pkg::OP_PSHM, 16'h7E7E, 1'b0);
      `CHK({done, top}, 17'h0_A001)
      @(posedge I_CLK);
      I_CE <= 1'b1;
   endtask
   task t_reset;
      @(posedge I_CLK);
      I_SYS_RST <= 1'b1;
      @(posedge I_CLK);
      #1;
      `CHK({acc, top, sel_n, strb_n, rw, busy, done}, 53'h1C)
      @(posedge I_CLK);
      I_SYS_RST <= 1'b0;
      op(dspk_pkg::OP_POPA, 16'h0000, 1'b0);
      `CHK({acc, top}, 48'h0)
   endtask
   task t_out(input logic [15:0] cnt, a, input logic rp, sh, sl, gp, input int nw);
      int n;
      periph_u.la.delete();
      periph_u.ld.delete();
      n_take = 0;
      @(posedge I_CLK);
      I_OP <= dspk_pkg::OP_OUT;
      {I_REPEAT_COUNTER, I_PORT_ADDR} <= {cnt, a};
      {I_REPEAT, I_SHARED_RAM, slow, gap, I_OP_VALID} <= {rp, sh, sl, gp, 1'b1};
      I_MEM_DATA <= 16'hD000;
      I_SRC_DATA <= 16'h5000;
      @(posedge I_CLK);
      I_OP_VALID <= 1'b0;
      #1;
      `CHK(busy, 1'b1)
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge I_CLK);
         #1;
         n++;
      end
      if (!sl && !gp) `CHK(n, (rp ? int'(cnt) : 0) + 1 + int'(sh))
      `CHK(periph_u.la.size(), nw)
      `CHK(n_take, rp ? int'(cnt) : 0)
      for (i = 0; i < periph_u.la.size(); i++) begin
         `CHK(periph_u.la[i], a + 16'(i))
         `CHK(periph_u.ld[i], i == 0 ? 16'hD000 : 16'h5000 + 16'(16'h0101 * (i - 1)))
      end
   endtask
   initial begin
      repeat (5) @(posedge I_CLK);
      I_SYS_RST <= 1'b0;
      t_stack;
      t_prod;
      t_shared;
      t_freeze;
      t_out(16'h0002, 16'h0100, 1'b1, 1'b0, 1'b0, 1'b0, 3);
      t_out(16'h0003, 16'h0200, 1'b1, 1'b0, 1'b1, 1'b0, 4);
      t_out(16'h0000, 16'h0300, 1'b0, 1'b1, 1'b0, 1'b0, 1);
      t_out(16'h0000, 16'h0301, 1'b0, 1'b0, 1'b0, 1'b0, 1);
      t_out(16'h0002, 16'h0400, 1'b1, 1'b0, 1'b0, 1'b1, 3);
      t_out(16'h0000, 16'h0055, 1'b0, 1'b0, 1'b0, 1'b0, 0);
      `CHK({mm_n == 1, mm_s, mm_d}, 21'h15_D000)
      t_reset;
      wrap_up;
   end
   // whole run needs well under a few thousand cycles
   initial begin
      #40000;
      n_mismatch++;
      wrap_up;
   end
endmodule
